// ---- core/l2c_hdr_check.sv ----
`timescale 1ns/1ps
// What this block does
// - without authentication and with udp, compute and insert control packet checksum
// - received unauthenticated control packet: drop on zero or failing checksum
// - with authentication and udp, control packet checksum may be sent as zero
// - transmitted data packets carry zero checksum unless ipv6 with data tx sum set
// - a received zero data or authenticated control checksum skips the check and accepts
// - nonzero data checksum may be skipped; verified over ipv6; tx sum optional
// - ipv6 control messages always carry a computed checksum
// - ipv6: verify every nonzero received control checksum
// - support a trailing ethernet crc-32 field
// - control header type flag is one on transmit
// - control header length-present flag is one on transmit
// - length field counts octets from the type flag, no session id
// - control header sequence-present flag is one on transmit
// - reserved header bits sent as zero, ignored on receive
// - four-bit protocol revision fixed at three
// - header carries connection id, then send and next expected sequence
// - rejected mandatory attribute tears down connection or session setup
// - hidden flag marks encrypted value; encryption not supported
// - attribute spare and reserved bits sent as zero, ignored on receive
// - attribute length is value length plus six header bytes
// - attribute carries vendor id, type, value; zero vendor is base protocol
// - unknown vendor with mandatory flag zero: discard attribute, continue
module l2c_hdr_check
	import l2c_pkg::*;
#(
	parameter logic [15:0] LOCAL_VENDOR = 16'h00A5 // arbitrary value
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic drop_pulse,
	output logic teardown
);

	// ones-complement 16-bit add with end-around carry
	function automatic logic [15:0] ones_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0] + {15'h0000, s[16]};
	endfunction : ones_add

	l2c_bus_e bus_state;
	logic a_valid, a_write, wr_en;
	logic [7:0] a_addr;
	logic [6:0] ctrl, status, next_status;
	logic [15:0] csum_field, sum, csum_out, msg_len, tx_sum, comp_sum;
	logic [31:0] crc_out, conn_id, seq, rx_hdr, avp_info, avp_txcfg, rd_mux;
	logic cmd_start, cmd_finish, data_wr, avp_wr;
	logic sum_ok, field_zero, rx_accept, rx_zero_drop, rx_bad_drop;
	logic vendor_known, avp_unsupported;
	logic [9:0] avp_len, tx_avp_len;

	// address phase capture; the data phase follows in the next cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			a_valid <= 1'b0;
			a_write <= 1'b0;
			a_addr <= 8'h00;
		end
		else if (hready)
		begin
			a_valid <= hsel && htrans[1] && (hsize == 3'b010);
			a_write <= hwrite;
			a_addr <= {haddr[7:2], 2'b00};
		end
	end

	assign wr_en = a_valid && a_write;

	// reads take one wait state so hrdata comes from a flop and sees prior writes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bus_state <= L2C_BUS_IDLE;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
		end
		else
		begin
			hresp <= 1'b0;
			case (bus_state)
				L2C_BUS_IDLE:
				begin
					if (hready && hsel && htrans[1] && !hwrite)
					begin
						bus_state <= L2C_BUS_RDWAIT;
						hreadyout <= 1'b0;
					end
				end
				L2C_BUS_RDWAIT:
				begin
					bus_state <= L2C_BUS_IDLE;
					hreadyout <= 1'b1;
					hrdata <= rd_mux;
				end
				default:
				begin
					bus_state <= L2C_BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	// unmapped addresses read as zero; write-only registers (command, data, attribute receive) also read as zero
	always_comb
	begin
		case (a_addr)
			L2C_CTRL_ADDR: rd_mux = {25'h0000000, ctrl};
			L2C_CSUM_FIELD_ADDR: rd_mux = {16'h0000, csum_field};
			L2C_CSUM_OUT_ADDR: rd_mux = {16'h0000, csum_out};
			L2C_CRC_OUT_ADDR: rd_mux = crc_out;
			L2C_STATUS_ADDR: rd_mux = {25'h0000000, status};
			L2C_CONN_ID_ADDR: rd_mux = conn_id;
			L2C_SEQ_ADDR: rd_mux = seq;
			L2C_MSG_LEN_ADDR: rd_mux = {16'h0000, msg_len};
			// type, length-present, sequence-present set; reserved bits zero
			L2C_TX_HDR0_ADDR: rd_mux = {3'b110, 1'b0, 1'b1, 7'h00,
				L2C_PROTO_REV, msg_len};
			L2C_TX_HDR1_ADDR: rd_mux = conn_id;
			L2C_TX_HDR2_ADDR: rd_mux = seq;
			L2C_RX_HDR_ADDR: rd_mux = rx_hdr;
			L2C_AVP_INFO_ADDR: rd_mux = avp_info;
			L2C_AVP_TXCFG_ADDR: rd_mux = avp_txcfg;
			// hidden flag always zero since values are never encrypted
			L2C_AVP_TXHDR_ADDR: rd_mux = {avp_txcfg[31], 1'b0, 4'h0, tx_avp_len,
				avp_txcfg[15:0]};
			default: rd_mux = 32'h00000000;
		endcase
	end

	assign tx_avp_len = avp_txcfg[25:16] + L2C_AVP_HDR_BYTES;

	// writable configuration words
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl <= L2C_CTRL_RESET;
			csum_field <= 16'h0000;
			conn_id <= 32'h00000000;
			seq <= 32'h00000000;
			msg_len <= 16'h0000;
			avp_txcfg <= 32'h00000000;
		end
		else if (wr_en)
		begin
			case (a_addr)
				L2C_CTRL_ADDR: ctrl <= hwdata[6:0];
				L2C_CSUM_FIELD_ADDR: csum_field <= hwdata[15:0];
				L2C_CONN_ID_ADDR: conn_id <= hwdata;
				L2C_SEQ_ADDR: seq <= hwdata;
				L2C_MSG_LEN_ADDR: msg_len <= hwdata[15:0];
				L2C_AVP_TXCFG_ADDR: avp_txcfg <= hwdata;
				default: ;
			endcase
		end
	end

	assign cmd_start = wr_en && (a_addr == L2C_CMD_ADDR) && hwdata[L2C_CMD_START];
	assign cmd_finish = wr_en && (a_addr == L2C_CMD_ADDR) && hwdata[L2C_CMD_FINISH];
	assign data_wr = wr_en && (a_addr == L2C_DATA_ADDR);
	assign avp_wr = wr_en && (a_addr == L2C_AVP_RX_ADDR);

	// running ones-complement sum over pseudo header, udp header and payload
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sum <= 16'h0000;
		else if (cmd_start)
			sum <= 16'h0000;
		else if (data_wr)
			sum <= ones_add(ones_add(sum, hwdata[31:16]), hwdata[15:0]);
	end

	l2c_crc32 u_crc (
		.hclk(hclk),
		.hresetn(hresetn),
		.init(cmd_start),
		.load(data_wr),
		.word(hwdata),
		.crc(crc_out)
	);

	// transmit checksum policy; a computed zero goes out as all ones
	always_comb
	begin
		comp_sum = ~sum;
		if (comp_sum == 16'h0000)
			comp_sum = L2C_SUM_ONES;
		tx_sum = 16'h0000;
		if (ctrl[L2C_CTRL_UDP_EN])
		begin
			if (ctrl[L2C_CTRL_IS_CTRL])
			begin
				if (ctrl[L2C_CTRL_IPV6])
					tx_sum = comp_sum;
				else if (!ctrl[L2C_CTRL_AUTH])
					tx_sum = comp_sum;
				else
					tx_sum = 16'h0000;
			end
			else if (ctrl[L2C_CTRL_IPV6] && ctrl[L2C_CTRL_DATA_TXSUM])
				tx_sum = comp_sum;
			else
				tx_sum = 16'h0000;
		end
	end

	assign sum_ok = (sum == L2C_SUM_ONES);
	assign field_zero = (csum_field == 16'h0000);

	// receive verdict; the fed words include the received checksum field
	always_comb
	begin
		rx_accept = 1'b1;
		rx_zero_drop = 1'b0;
		rx_bad_drop = 1'b0;
		if (ctrl[L2C_CTRL_UDP_EN])
		begin
			if (ctrl[L2C_CTRL_IS_CTRL])
			begin
				if (field_zero && !ctrl[L2C_CTRL_AUTH])
				begin
					rx_accept = 1'b0;
					rx_zero_drop = 1'b1;
				end
				else if (!field_zero && !sum_ok)
				begin
					// verified with or without authentication, over ipv4 and over ipv6
					rx_accept = 1'b0;
					rx_bad_drop = 1'b1;
				end
			end
			else if (!field_zero && !sum_ok
				&& (ctrl[L2C_CTRL_IPV6] || ctrl[L2C_CTRL_DATA_RXCHK]))
			begin
				rx_accept = 1'b0;
				rx_bad_drop = 1'b1;
			end
		end
		// otherwise a zero field passes unchecked
		if (field_zero && !(ctrl[L2C_CTRL_IS_CTRL] && !ctrl[L2C_CTRL_AUTH]))
			rx_accept = 1'b1;
	end

	// checksum result latched on a transmit finish (receive finish leaves it at zero) so it is stable for readback
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			csum_out <= 16'h0000;
		else if (cmd_start)
			csum_out <= 16'h0000;
		else if (cmd_finish && !ctrl[L2C_CTRL_RX])
			csum_out <= tx_sum;
	end

	// received control header; reserved bits are stored but never judged
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rx_hdr <= 32'h00000000;
		else if (wr_en && (a_addr == L2C_RX_HDR_ADDR))
			rx_hdr <= hwdata;
	end

	// attribute header fields: flags, spare bits, length, vendor
	assign avp_len = hwdata[25:16];
	assign vendor_known = (hwdata[15:0] == L2C_BASE_VENDOR)
		|| (hwdata[15:0] == LOCAL_VENDOR);
	// hidden values cannot be decoded, so they count as unsupported
	assign avp_unsupported = !vendor_known || hwdata[30]
		|| (avp_len < L2C_AVP_HDR_BYTES);

	// parsed attribute: value length and verdict, spare bits dropped
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			avp_info <= 32'h00000000;
		else if (avp_wr)
			avp_info <= {hwdata[31], hwdata[30], avp_unsupported, 3'b000,
				avp_len - L2C_AVP_HDR_BYTES, hwdata[15:0]};
	end

	// sticky status; a hardware set in the same cycle beats a software clear
	always_comb
	begin
		next_status = status;
		if (wr_en && (a_addr == L2C_STATUS_ADDR))
			next_status = status & ~hwdata[6:0];
		if (cmd_finish && ctrl[L2C_CTRL_RX])
		begin
			next_status[L2C_ST_DONE] = 1'b1;
			if (rx_accept)
				next_status[L2C_ST_ACCEPT] = 1'b1;
			if (rx_zero_drop)
				next_status[L2C_ST_DROP_ZERO] = 1'b1;
			if (rx_bad_drop)
				next_status[L2C_ST_DROP_BAD] = 1'b1;
		end
		if (cmd_finish && !ctrl[L2C_CTRL_RX])
			next_status[L2C_ST_DONE] = 1'b1;
		if (avp_wr && avp_unsupported)
		begin
			if (hwdata[31])
				next_status[L2C_ST_TEARDOWN] = 1'b1;
			else
				next_status[L2C_ST_AVP_DISCARD] = 1'b1;
		end
		if (wr_en && (a_addr == L2C_RX_HDR_ADDR)
			&& (!hwdata[31] || !hwdata[30] || !hwdata[27] || (hwdata[19:16] != L2C_PROTO_REV)))
			next_status[L2C_ST_HDR_BAD] = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			status <= 7'h00;
		else
			status <= next_status;
	end

	// teardown request follows its sticky bit; drop is a one-cycle event
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			teardown <= 1'b0;
			drop_pulse <= 1'b0;
		end
		else
		begin
			teardown <= next_status[L2C_ST_TEARDOWN];
			drop_pulse <= cmd_finish && ctrl[L2C_CTRL_RX] && !rx_accept;
		end
	end

endmodule : l2c_hdr_check

// ---- core/l2c_pkg.sv ----
package l2c_pkg;

	// register byte addresses
	localparam logic [7:0] L2C_CTRL_ADDR = 8'h00;
	localparam logic [7:0] L2C_CMD_ADDR = 8'h04;
	localparam logic [7:0] L2C_DATA_ADDR = 8'h08;
	localparam logic [7:0] L2C_CSUM_FIELD_ADDR = 8'h0C;
	localparam logic [7:0] L2C_CSUM_OUT_ADDR = 8'h10;
	localparam logic [7:0] L2C_CRC_OUT_ADDR = 8'h14;
	localparam logic [7:0] L2C_STATUS_ADDR = 8'h18;
	localparam logic [7:0] L2C_CONN_ID_ADDR = 8'h1C;
	localparam logic [7:0] L2C_SEQ_ADDR = 8'h20;
	localparam logic [7:0] L2C_MSG_LEN_ADDR = 8'h24;
	localparam logic [7:0] L2C_TX_HDR0_ADDR = 8'h28;
	localparam logic [7:0] L2C_TX_HDR1_ADDR = 8'h2C;
	localparam logic [7:0] L2C_TX_HDR2_ADDR = 8'h30;
	localparam logic [7:0] L2C_RX_HDR_ADDR = 8'h34;
	localparam logic [7:0] L2C_AVP_RX_ADDR = 8'h38;
	localparam logic [7:0] L2C_AVP_INFO_ADDR = 8'h3C;
	localparam logic [7:0] L2C_AVP_TXCFG_ADDR = 8'h40;
	localparam logic [7:0] L2C_AVP_TXHDR_ADDR = 8'h44;

	// control register fields
	localparam int L2C_CTRL_UDP_EN = 0;
	localparam int L2C_CTRL_AUTH = 1;
	localparam int L2C_CTRL_IPV6 = 2;
	localparam int L2C_CTRL_IS_CTRL = 3;
	localparam int L2C_CTRL_DATA_TXSUM = 4;
	localparam int L2C_CTRL_DATA_RXCHK = 5;
	localparam int L2C_CTRL_RX = 6;
	localparam int L2C_CTRL_W = 7;
	localparam logic [6:0] L2C_CTRL_RESET = 7'h01;

	// command bits
	localparam int L2C_CMD_START = 0;
	localparam int L2C_CMD_FINISH = 1;

	// status bits, write one to clear
	localparam int L2C_ST_ACCEPT = 0;
	localparam int L2C_ST_DROP_ZERO = 1;
	localparam int L2C_ST_DROP_BAD = 2;
	localparam int L2C_ST_AVP_DISCARD = 3;
	localparam int L2C_ST_TEARDOWN = 4;
	localparam int L2C_ST_HDR_BAD = 5;
	localparam int L2C_ST_DONE = 6;
	localparam int L2C_ST_W = 7;

	// header constants
	localparam logic [3:0] L2C_PROTO_REV = 4'h3;
	localparam logic [9:0] L2C_AVP_HDR_BYTES = 10'h006;
	localparam logic [15:0] L2C_BASE_VENDOR = 16'h0000;
	localparam logic [15:0] L2C_SUM_ONES = 16'hFFFF;
	localparam logic [31:0] L2C_CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] L2C_CRC_POLY = 32'hEDB88320;

	// bus read sequencing
	typedef enum logic [1:0] {
		L2C_BUS_IDLE = 2'b01,
		L2C_BUS_RDWAIT = 2'b10
	} l2c_bus_e;

endpackage : l2c_pkg

// ---- core/l2c_crc32.sv ----
`timescale 1ns/1ps
module l2c_crc32
	import l2c_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic init,
	input wire logic load,
	input wire logic [31:0] word,
	output logic [31:0] crc
);

	logic [31:0] state;
	logic [31:0] next_state;

	// reflected ethernet crc, four bytes a word, most significant byte first
	always_comb
	begin
		next_state = state;
		for (int b = 3; b >= 0; b--)
		begin
			next_state = next_state ^ {24'h000000, word[b*8 +: 8]};
			for (int k = 0; k < 8; k++)
			begin
				next_state = next_state[0] ? ((next_state >> 1) ^ L2C_CRC_POLY)
					: (next_state >> 1);
			end
		end
	end

	// running remainder; init wins so a fresh frame never inherits old bytes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state <= L2C_CRC_INIT;
		else if (init)
			state <= L2C_CRC_INIT;
		else if (load)
			state <= next_state;
	end

	// final inversion kept in a register so the bus reads a flop
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			crc <= 32'h00000000;
		else if (init)
			crc <= 32'h00000000;
		else if (load)
			crc <= ~next_state;
	end

endmodule : l2c_crc32

// ---- verification/l2c_hdr_check_asserts.sv ----
`timescale 1ns/1ps
module l2c_hdr_check_asserts
	import l2c_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic drop_pulse,
	input wire logic teardown
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic tk;
	logic [7:0] wa;
	logic [1:0] age;
	// transfer accepted this cycle
	assign tk = hready && hsel && htrans[1];
	// last write address and its age, saturating so stale writes stop counting
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			wa <= 8'hFF;
			age <= 2'h3;
		end
		else if (tk && hwrite)
		begin
			wa <= haddr[7:0];
			age <= 2'h0;
		end
		else if (age != 2'h3)
			age <= age + 2'h1;
	sequence s_rd;
		tk && !hwrite;
	endsequence
	sequence s_stall;
		!hreadyout ##1 hreadyout;
	endsequence
	a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
	a_read_stall: assert property (s_rd |=> s_stall) else $error("read wait state wrong");
	a_write_nowait: assert property (tk && hwrite |=> hreadyout) else $error("write stalled");
	a_stall_cause: assert property (!hreadyout |-> $past(tk) && !$past(hwrite))
		else $error("stall without read");
	a_hdr0_flags: assert property (s_rd and haddr[7:0] == L2C_TX_HDR0_ADDR
		|-> ##2 hrdata[31:16] == 16'hC803) else $error("tx header flags wrong");
	a_cmd_rdzero: assert property (s_rd and haddr[7:0] == L2C_CMD_ADDR
		|-> ##2 hrdata == 32'h0) else $error("command read not zero");
	a_drop_cause: assert property (drop_pulse |-> wa == L2C_CMD_ADDR && age == 2'h1)
		else $error("drop pulse without finish");
	a_drop_single: assert property (drop_pulse |=> !drop_pulse) else $error("drop pulse long");
	a_td_rise: assert property ($rose(teardown) |-> wa == L2C_AVP_RX_ADDR && age == 2'h1)
		else $error("teardown without attribute");
	a_td_fall: assert property ($fell(teardown) |-> wa == L2C_STATUS_ADDR && age == 2'h1)
		else $error("teardown fell without clear");
endmodule : l2c_hdr_check_asserts
bind l2c_hdr_check l2c_hdr_check_asserts u_l2c_hdr_check_asserts (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.hresp(hresp), .drop_pulse(drop_pulse), .teardown(teardown));

// ---- verification/l2c_peer.sv ----
`timescale 1ns/1ps
module l2c_peer
	import l2c_pkg::*;
(
	input wire logic [1:0] mode,
	output logic [127:0] frame,
	output logic [15:0] good
);
	localparam logic [127:0] BASE = 128'hC0A80001_00110010_06A506A5_C8030000;
	logic [19:0] s;
	logic [15:0] f;
	// sum over the frame with the field at zero; 0 maps to all ones
	always_comb
	begin
		s = 20'h0;
		for (int i = 0; i < 8; i++)
			s = s + {4'h0, BASE[127 - 16 * i -: 16]};
		s = {4'h0, s[15:0]} + {16'h0, s[19:16]};
		s = {4'h0, s[15:0]} + {16'h0, s[19:16]};
		f = ~s[15:0];
		good = (f == 16'h0) ? 16'hFFFF : f;
	end
	// mode 1 damages a bit of the second frame word after the sum is fixed, like a bad wire; mode 2 sends zero
	assign frame = {BASE[127:16] ^ ((mode == 2'h1) ? 112'h100_00000000_00000000 : 112'h0),
		(mode == 2'h2) ? 16'h0 : good};
endmodule : l2c_peer

// ---- verification/l2tpv3_ctrl_hdr_udp_check_test.sv ----
`timescale 1ns/1ps
module l2tpv3_ctrl_hdr_udp_check_test;
	import l2c_pkg::*;
	typedef struct packed {logic [6:0] c; logic [1:0] m; logic [6:0] s; logic k;} l2c_row_s;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] mode = 2'h0;
	logic hreadyout, hresp, drop_pulse, teardown;
	logic [31:0] hrdata, rd, crc;
	logic [127:0] frame;
	logic [15:0] good;
	int n_fail = 0;
	int comparisons = 0;
	int n_drop = 0;
	int exp_drop = 0;
	wire hready = hreadyout;
	// ctrl, peer mode, status, checksum out expected
	l2c_row_s rows [16] = '{'{7'h49, 2'h2, 7'h42, 1'h0}, '{7'h49, 2'h1, 7'h44, 1'h0},
		'{7'h49, 2'h0, 7'h41, 1'h0}, '{7'h4F, 2'h1, 7'h44, 1'h0}, '{7'h4B, 2'h2, 7'h41, 1'h0},
		'{7'h41, 2'h1, 7'h41, 1'h0}, '{7'h45, 2'h1, 7'h44, 1'h0}, '{7'h45, 2'h2, 7'h41, 1'h0},
		'{7'h48, 2'h1, 7'h41, 1'h0}, '{7'h09, 2'h2, 7'h40, 1'h1}, '{7'h0B, 2'h2, 7'h40, 1'h0},
		'{7'h0F, 2'h2, 7'h40, 1'h1}, '{7'h01, 2'h2, 7'h40, 1'h0}, '{7'h15, 2'h2, 7'h40, 1'h1},
		'{7'h61, 2'h1, 7'h44, 1'h0}, '{7'h08, 2'h2, 7'h40, 1'h0}};
	// free running bus clock
	always #20 hclk = ~hclk;
	// drop events are counted here because the pulse is gone before any read returns
	always @(posedge hclk)
		if (drop_pulse === 1'b1)
			n_drop <= n_drop + 1;
	l2c_hdr_check u_l2c_hdr_check (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .drop_pulse(drop_pulse),
		.teardown(teardown));
	l2c_peer u_l2c_peer (.mode(mode), .frame(frame), .good(good));
	task automatic stop_test();
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	// bounded wait so a stuck slave ends the run instead of hanging it
	task automatic wait_rdy();
		int i;
		i = 0;
		@(posedge hclk);
		while (hready !== 1'b1)
		begin
			i++;
			if (i > 20)
			begin
				n_fail++;
				stop_test();
			end
			@(posedge hclk);
		end
	endtask : wait_rdy
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask : bus
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : rdchk
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c ^ {24'h0, b};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ L2C_CRC_POLY) : (r >> 1);
		return r;
	endfunction : crc_byte
	// main sequence: table of frames, then header, attribute and reset cases
	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk("ctrl", L2C_CTRL_ADDR, 32'h1);
		for (int r = 0; r < 16; r++)
		begin
			mode <= rows[r].m;
			bus(1'b1, L2C_CTRL_ADDR, {25'h0, rows[r].c});
			bus(1'b1, L2C_CMD_ADDR, 32'h1);
			crc = L2C_CRC_INIT;
			for (int i = 0; i < 4; i++)
			begin
				bus(1'b1, L2C_DATA_ADDR, frame[127 - 32 * i -: 32]);
				for (int b = 0; b < 4; b++)
					crc = crc_byte(crc, frame[127 - 32 * i - 8 * b -: 8]);
			end
			bus(1'b1, L2C_CSUM_FIELD_ADDR, {16'h0, frame[15:0]});
			bus(1'b1, L2C_CMD_ADDR, 32'h2);
			rdchk("status", L2C_STATUS_ADDR, {25'h0, rows[r].s});
			if (rows[r].s[2:1] != 2'h0)
				exp_drop++;
			chk("drop", exp_drop, n_drop);
			rdchk("csum", L2C_CSUM_OUT_ADDR, rows[r].k ? {16'h0, good} : 32'h0);
			rdchk("crc", L2C_CRC_OUT_ADDR, ~crc);
			bus(1'b1, L2C_STATUS_ADDR, 32'h7F);
		end
		bus(1'b1, L2C_MSG_LEN_ADDR, 32'h24);
		bus(1'b1, L2C_CONN_ID_ADDR, 32'h89ABCDEF);
		bus(1'b1, L2C_SEQ_ADDR, 32'h00070003);
		rdchk("hdr0", L2C_TX_HDR0_ADDR, 32'hC8030024);
		rdchk("hdr1", L2C_TX_HDR1_ADDR, 32'h89ABCDEF);
		rdchk("hdr2", L2C_TX_HDR2_ADDR, 32'h00070003);
		bus(1'b1, L2C_RX_HDR_ADDR, 32'hFFF30010);
		rdchk("hdr ok", L2C_STATUS_ADDR, 32'h0);
		bus(1'b1, L2C_RX_HDR_ADDR, 32'hFFF20010);
		rdchk("hdr bad", L2C_STATUS_ADDR, 32'h20);
		bus(1'b1, L2C_AVP_TXCFG_ADDR, 32'hFFFC00A5);
		rdchk("avp tx", L2C_AVP_TXHDR_ADDR, 32'h800200A5);
		bus(1'b1, L2C_STATUS_ADDR, 32'h7F);
		bus(1'b1, L2C_AVP_RX_ADDR, 32'h1C0A1234);
		rdchk("avp info", L2C_AVP_INFO_ADDR, 32'h20041234);
		rdchk("discard", L2C_STATUS_ADDR, 32'h08);
		bus(1'b1, L2C_AVP_RX_ADDR, 32'h800A00A5);
		rdchk("known", L2C_STATUS_ADDR, 32'h08);
		bus(1'b1, L2C_AVP_RX_ADDR, 32'hC00A0000);
		rdchk("hidden", L2C_STATUS_ADDR, 32'h18);
		chk("teardown", 32'h1, {31'h0, teardown});
		bus(1'b1, L2C_STATUS_ADDR, 32'h10);
		rdchk("sts clr", L2C_STATUS_ADDR, 32'h08);
		chk("td clr", 32'h0, {31'h0, teardown});
		bus(1'b1, 8'h48, 32'hFFFFFFFF);
		rdchk("unmapped", 8'h48, 32'h0);
		rdchk("cmd", L2C_CMD_ADDR, 32'h0);
		bus(1'b1, L2C_AVP_RX_ADDR, 32'h800A1234);
		bus(1'b1, L2C_CTRL_ADDR, 32'h4F);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("td rst", 32'h0, {31'h0, teardown});
		rdchk("ctrl rst", L2C_CTRL_ADDR, 32'h1);
		rdchk("sts rst", L2C_STATUS_ADDR, 32'h0);
		stop_test();
	end
endmodule : l2tpv3_ctrl_hdr_udp_check_test
